// ==== parallel_port_modes_0_1_test.sv ====
// Self-checking testbench for the parallel port core.
module parallel_port_modes_0_1_test import ppm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] cw; logic [7:0] ea; logic [7:0] eb; logic [7:0] ec;} ppm_row_s;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata, pa_in, pb_in, pc_in, pa_out, pb_out, pc_out, pa_oe_n, pb_oe_n, pc_oe_n;
  logic [7:0] q;
  int n_fail = 0;
  int checks = 0;
  // Basic mode rows: latches 5A A5 3C, far side drives C3 96 69.
  ppm_row_s rows [7] = '{
    '{8'h80, 8'h5A, 8'hA5, 8'h3C}, '{8'h90, 8'hC3, 8'hA5, 8'h3C},
    '{8'h82, 8'h5A, 8'h96, 8'h3C}, '{8'h89, 8'h5A, 8'hA5, 8'h69},
    '{8'h88, 8'h5A, 8'hA5, 8'h6C}, '{8'h81, 8'h5A, 8'hA5, 8'h39},
    '{8'h9B, 8'hC3, 8'h96, 8'h69}};

  // Clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;

  ppm_core DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe_n(pc_oe_n));

  ppm_periph P (.clk_sys(clk_sys), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out),
    .pb_oe_n(pb_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pa_in(pa_in), .pb_in(pb_in),
    .pc_in(pc_in));

  // ************************************
  // Bus cycles and comparison
  // ************************************
  // One-cycle register write.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Byte comparison with case equality.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run of about 200 cycles.
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end

  // ************************************
  // Test sequence
  // ************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    chk8(pa_oe_n & pb_oe_n & pc_oe_n, 8'hFF, "reset dir");
    chk8(pa_out | pb_out | pc_out | rdata, 8'h00, "reset out");
    nrst <= 1'b1;
    rd(PPM_ADDR_CW, q);
    chk8(q, 8'h00, "cw read");
    $display("test reset done");
    // Basic mode direction table.
    foreach (rows[i]) begin
      wr(PPM_ADDR_CW, rows[i].cw);
      wr(PPM_ADDR_A, 8'h5A);
      wr(PPM_ADDR_B, 8'hA5);
      wr(PPM_ADDR_C, 8'h3C);
      P.ext_a <= 8'hC3;
      P.ext_b <= 8'h96;
      P.ext_c <= 8'h69;
      rd(PPM_ADDR_A, q);
      chk8(q, rows[i].ea, "port A");
      rd(PPM_ADDR_B, q);
      chk8(q, rows[i].eb, "port B");
      rd(PPM_ADDR_C, q);
      chk8(q, rows[i].ec, "port C");
      chk8(pa_oe_n, {8{rows[i].cw[4]}}, "A dir");
      chk8(pc_oe_n, {{4{rows[i].cw[3]}}, {4{rows[i].cw[0]}}}, "C dir");
      chk8(pb_out, (rows[i].cw[1] ? pb_out : 8'hA5), "B pins");
    end
    $display("test basic done");
    // Inputs are read live, not latched.
    P.ext_a <= 8'h11;
    rd(PPM_ADDR_A, q);
    chk8(q, 8'h11, "live A");
    $display("test live done");
    // Bit set of every port C line, reset of line 3, mode untouched.
    wr(PPM_ADDR_CW, PPM_CW_ALL_OUT);
    for (int i = 0; i < 8; i++) begin
      wr(PPM_ADDR_CW, {4'h0, i[2:0], 1'b1});
      rd(PPM_ADDR_C, q);
      chk8(q, 8'hFF >> (7 - i), "bit set");
    end
    wr(PPM_ADDR_CW, 8'h06);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'hF7, "bit clear");
    chk8(pa_oe_n | pb_oe_n, 8'h00, "mode kept");
    ce <= 1'b0;
    wr(PPM_ADDR_A, 8'h55);
    ce <= 1'b1;
    rd(PPM_ADDR_A, q);
    chk8(q, 8'h00, "frozen write");
    $display("test bit command done");
    // Strobed input on both ports.
    P.ext_c <= 8'hFF;
    wr(PPM_ADDR_CW, 8'hB6);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'h00, "idle status");
    wr(PPM_ADDR_CW, 8'h09);
    wr(PPM_ADDR_CW, 8'h05);
    wr(PPM_ADDR_CW, 8'h0F);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'h94, "enables");
    P.strobe(1'b0, 8'h3E, 1);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'hBC, "A full");
    chk8({pc_out[7], pc_out[5], pc_out[3], pc_oe_n[4]}, 8'h0F, "A pins");
    rd(PPM_ADDR_A, q);
    chk8(q, 8'h3E, "A byte");
    rd(PPM_ADDR_C, q);
    chk8(q, 8'h94, "A cleared");
    P.strobe(1'b1, 8'hD1, 3);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'h97, "B full");
    rd(PPM_ADDR_B, q);
    chk8(q, 8'hD1, "B byte");
    rd(PPM_ADDR_C, q);
    chk8(q, 8'h94, "B cleared");
    wr(PPM_ADDR_CW, 8'h08);
    P.strobe(1'b0, 8'h77, 2);
    P.strobe(1'b0, 8'h78, 1);
    rd(PPM_ADDR_C, q);
    chk8(q, 8'hA4, "no request");
    rd(PPM_ADDR_A, q);
    chk8(q, 8'h78, "overwrite");
    $display("test strobed done");
    // Reset in mid-run returns every pin to input.
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk8(pa_oe_n & pb_oe_n & pc_oe_n, 8'hFF, "second reset");
    $display("test second reset done");
    end_sim();
  end
endmodule : parallel_port_modes_0_1_test

// ==== ppm_core.sv ====
// Parallel port core: control word, ports A, B and C, strobed input.
// What this block does
// RULE1 - Twenty-four lines as three eight-bit ports A, B and C.
// RULE2 - Group one is A plus C7..C4; group two is B plus C3..C0.
// RULE3 - One eight-bit control word sets both group modes when written.
// RULE4 - Flag bit 7 high: bits 6..0 give directions and group modes.
// RULE5 - Flag bit 7 low: bits 3..0 set or clear one C bit only.
// RULE6 - Mode field picks basic, strobed or bidirectional operation; bidirectional and strobed output act as basic here.
// RULE7 - Basic mode moves data straight on each access, no handshake.
// RULE8 - Basic mode: A, B and each C nibble pick direction freely.
// RULE9 - Basic outputs are latched; inputs are read live from the pins.
// RULE10 - Word 80 hex makes every port a basic output.
// RULE11 - 90 hex makes A input, 82 hex B input, 89 hex C inputs.
// RULE12 - Strobed mode handshakes A and B through port C lines; here only a port set as input handshakes.
// RULE13 - Strobed data port is eight bits and its data are latched.
// RULE14 - Strobed input on A leaves lines six and seven general purpose.
// RULE15 - Word with bits 7, 2 and 1 set makes B a strobed input.
// RULE16 - Strobed B gets no spare general port C lines.
// RULE17 - C status: general, A full, A enable, A request, B enable, full, request.
// RULE18 - Buffer full rises once a byte sits in the input latch.
// RULE19 - A enable written through line four, B enable through line two.
// RULE20 - Request bit is high exactly while enable and full are high.
// RULE21 - Status word never shows the strobe line levels.
// RULE22 - Low strobe loads a byte; a host read clears full and request.
// RULE23 - Bit command: bits 3..1 pick the C line, bit 0 its value.
//
// Design decisions made here: the placing of the registers and the strobed register port.
module ppm_core import ppm_pkg::*; (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [PPM_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_n,
  // Port B pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe_n,
  // Port C pins
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe_n
);

  // ************************************
  // Address decode
  // ************************************

  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_cw;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_cw;
  logic rd_a;
  logic rd_b;
  logic rd_c;

  // One select per register, qualified by the strobes.
  assign hit_a = addr == PPM_ADDR_A;
  assign hit_b = addr == PPM_ADDR_B;
  assign hit_c = addr == PPM_ADDR_C;
  assign hit_cw = addr == PPM_ADDR_CW;
  assign wr_a = wr_en && hit_a;
  assign wr_b = wr_en && hit_b;
  assign wr_c = wr_en && hit_c;
  assign wr_cw = wr_en && hit_cw;
  assign rd_a = rd_en && hit_a;
  assign rd_b = rd_en && hit_b;
  assign rd_c = rd_en && hit_c;

  // ************************************
  // Control word
  // ************************************

  logic [7:0] cfg;
  logic mode_set;
  logic bsr_hit;
  logic [2:0] bsr_sel;
  logic bsr_val;
  logic a_in;
  logic b_in;
  logic cu_in;
  logic cl_in;
  ppm_gmode_e a_mode;
  ppm_gmode_e b_mode;
  logic a_strobed;
  logic b_strobed;

  // RULE3 decode written word
  ppm_cword u_cword (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .wr_cw(wr_cw),
    .wdata(wdata),
    .cfg(cfg),
    .mode_set(mode_set),
    .bsr_hit(bsr_hit),
    .bsr_sel(bsr_sel),
    .bsr_val(bsr_val),
    .a_in(a_in),
    .b_in(b_in),
    .cu_in(cu_in),
    .cl_in(cl_in),
    .a_mode(a_mode),
    .b_mode(b_mode)
  );

  // Strobed input is the only handshake mode served; others act as basic.
  assign a_strobed = a_mode == PPM_GM_STROBED_IN;
  assign b_strobed = b_mode == PPM_GM_STROBED_IN;

  // ************************************
  // Strobed input channels
  // ************************************

  logic a_strobe_n;
  logic b_strobe_n;
  logic [7:0] a_data;
  logic [7:0] b_data;
  logic a_input_full;
  logic b_input_full;
  logic a_irq_enable;
  logic b_irq_enable;
  logic a_irq_request;
  logic b_irq_request;
  logic a_take;
  logic b_take;
  logic a_ie_wr;
  logic b_ie_wr;

  // RULE12 strobes arrive on port C
  assign a_strobe_n = pc_in[PPM_PC_A_STB];
  assign b_strobe_n = pc_in[PPM_PC_B_STB];
  // RULE22 host read empties latch
  assign a_take = rd_a && a_strobed;
  assign b_take = rd_b && b_strobed;
  // RULE19 enables via line four and two
  assign a_ie_wr = bsr_hit && a_strobed && bsr_sel == PPM_BSR_A_IE;
  assign b_ie_wr = bsr_hit && b_strobed && bsr_sel == PPM_BSR_B_IE;

  // Channel for port A.
  ppm_strobe_chan #(.W(PPM_PORT_W)) u_chan_a (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(a_strobed),
    .strobe_n(a_strobe_n),
    .din(pa_in),
    .rd_take(a_take),
    .ie_wr(a_ie_wr),
    .ie_val(bsr_val),
    .clr(mode_set),
    .data(a_data),
    .full(a_input_full),
    .ie(a_irq_enable),
    .irq(a_irq_request)
  );

  // Channel for port B.
  ppm_strobe_chan #(.W(PPM_PORT_W)) u_chan_b (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(b_strobed),
    .strobe_n(b_strobe_n),
    .din(pb_in),
    .rd_take(b_take),
    .ie_wr(b_ie_wr),
    .ie_val(bsr_val),
    .clr(mode_set),
    .data(b_data),
    .full(b_input_full),
    .ie(b_irq_enable),
    .irq(b_irq_request)
  );

  // ************************************
  // Port C drive, direction and status
  // ************************************

  logic [7:0] pc_latch;
  logic [7:0] next_pc_latch;
  logic [7:0] pc_dir_in;
  logic [7:0] pc_drive;
  logic [7:0] pc_dir;
  logic [7:0] pc_status;

  // RULE2 nibbles follow their group
  assign pc_dir_in = {{PPM_NIB_W{cu_in}}, {PPM_NIB_W{cl_in}}};

  // Port C latch: write, bit command, cleared by a new mode word.
  always_comb begin
    next_pc_latch = pc_latch;
    if (mode_set) begin
      next_pc_latch = PPM_BYTE_ZERO;
    end else if (wr_c) begin
      next_pc_latch = wdata;
    end else if (bsr_hit) begin
      // RULE5 single line changes
      next_pc_latch[bsr_sel] = bsr_val;
    end
  end

  // Handshake lines override the general nibble settings.
  always_comb begin
    pc_drive = pc_latch;
    pc_dir = pc_dir_in;
    // RULE9 live input, latched output
    pc_status = (pc_dir_in & pc_in) | (~pc_dir_in & pc_latch);
    // RULE14 lines six, seven stay general
    if (a_strobed) begin
      pc_drive[PPM_PC_A_FULL] = a_input_full;
      pc_drive[PPM_PC_A_IRQ] = a_irq_request;
      pc_dir[PPM_PC_A_STB] = 1'b1;
      pc_dir[PPM_PC_A_FULL] = 1'b0;
      pc_dir[PPM_PC_A_IRQ] = 1'b0;
      // RULE21 enable hides strobe level
      pc_status[PPM_PC_A_FULL] = a_input_full;
      pc_status[PPM_PC_A_IE] = a_irq_enable;
      pc_status[PPM_PC_A_IRQ] = a_irq_request;
    end
    // RULE16 B takes all three lines
    if (b_strobed) begin
      pc_drive[PPM_PC_B_FULL] = b_input_full;
      pc_drive[PPM_PC_B_IRQ] = b_irq_request;
      pc_dir[PPM_PC_B_STB] = 1'b1;
      pc_dir[PPM_PC_B_FULL] = 1'b0;
      pc_dir[PPM_PC_B_IRQ] = 1'b0;
      // RULE17 status word layout
      pc_status[PPM_PC_B_IE] = b_irq_enable;
      pc_status[PPM_PC_B_FULL] = b_input_full;
      pc_status[PPM_PC_B_IRQ] = b_irq_request;
    end
  end

  // ************************************
  // Ports A and B and read data
  // ************************************

  logic [7:0] next_pa_out;
  logic [7:0] next_pb_out;
  logic [7:0] a_read;
  logic [7:0] b_read;
  logic [7:0] next_rdata;

  // RULE9 output latches hold writes
  assign next_pa_out = mode_set ? PPM_BYTE_ZERO : (wr_a ? wdata : pa_out);
  assign next_pb_out = mode_set ? PPM_BYTE_ZERO : (wr_b ? wdata : pb_out);

  // RULE7 basic read is direct
  assign a_read = a_strobed ? a_data : (a_in ? pa_in : pa_out);
  assign b_read = b_strobed ? b_data : (b_in ? pb_in : pb_out);

  // Control word reads back as zero, being write-only.
  assign next_rdata = hit_a ? a_read : hit_b ? b_read : hit_c ? pc_status : PPM_BYTE_ZERO;

  // RULE1 three eight-bit ports
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pa_out <= PPM_BYTE_ZERO;
      pb_out <= PPM_BYTE_ZERO;
      pc_latch <= PPM_BYTE_ZERO;
      pc_out <= PPM_BYTE_ZERO;
    end else if (ce) begin
      pa_out <= next_pa_out;
      pb_out <= next_pb_out;
      pc_latch <= next_pc_latch;
      pc_out <= pc_drive;
    end
  end

  // RULE8 independent port directions
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pa_oe_n <= PPM_ALL_HIGH;
      pb_oe_n <= PPM_ALL_HIGH;
      pc_oe_n <= PPM_ALL_HIGH;
    end else if (ce) begin
      // RULE10 low enable drives pins
      pa_oe_n <= {PPM_PORT_W{a_in}};
      pb_oe_n <= {PPM_PORT_W{b_in}};
      // RULE11 direction bits per port
      pc_oe_n <= pc_dir;
    end
  end

  // Read data register, loaded only by a read strobe.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= PPM_BYTE_ZERO;
    end else if (ce && rd_en) begin
      rdata <= next_rdata;
    end
  end

  // ************************************
  // Checks
  // ************************************

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_rd_c;
    ce && rd_c;
  endsequence

  sequence s_word_then_ce(logic [7:0] w);
    (ce && mode_set && wdata == w) ##1 ce;
  endsequence

  a_status_layout: assert property (s_rd_c && a_strobed && b_strobed |=> // RULE17
    rdata[PPM_PC_A_FULL] == $past(a_input_full) && rdata[PPM_PC_A_IE] == $past(a_irq_enable)
    && rdata[PPM_PC_B_IE] == $past(b_irq_enable) && rdata[PPM_PC_B_FULL] == $past(b_input_full))
    else $error("Port C status layout wrong.");
  a_irq_status: assert property (s_rd_c && a_strobed |=> // RULE20
    rdata[PPM_PC_A_IRQ] == $past(a_irq_enable && a_input_full))
    else $error("Port A request status wrong.");
  a_irq_pin: assert property (ce && b_strobed |=> // RULE20
    pc_out[PPM_PC_B_IRQ] == $past(b_irq_enable && b_input_full))
    else $error("Port B request line wrong.");
  a_out_latch: assert property (ce && wr_a |=> pa_out == $past(wdata)) // RULE9
    else $error("Port A latch missed a write.");
  a_live_read: assert property (ce && rd_b && !b_strobed && b_in |=> // RULE9
    rdata == $past(pb_in))
    else $error("Basic input read not live.");
  a_all_out: assert property (s_word_then_ce(PPM_CW_ALL_OUT) |=> // RULE10
    pa_oe_n == PPM_BYTE_ZERO && pb_oe_n == PPM_BYTE_ZERO && pc_oe_n == PPM_BYTE_ZERO)
    else $error("Word 80 did not make all outputs.");
  a_bsr_line: assert property (ce && bsr_hit && !a_strobed && !b_strobed |=> // RULE23
    pc_latch[$past(bsr_sel)] == $past(bsr_val))
    else $error("Bit command missed its line.");
  a_strobed_read: assert property (ce && rd_a && a_strobed |=> // RULE13
    rdata == $past(a_data))
    else $error("Strobed read not from latch.");

endmodule : ppm_core

// ==== ppm_cword.sv ====
// Control word register, its decode and the port C bit set/reset command.
module ppm_cword import ppm_pkg::*; (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Control word write
  input wire logic wr_cw,
  input wire logic [7:0] wdata,
  // Decoded configuration
  output logic [7:0] cfg,
  output logic mode_set,
  output logic bsr_hit,
  output logic [2:0] bsr_sel,
  output logic bsr_val,
  output logic a_in,
  output logic b_in,
  output logic cu_in,
  output logic cl_in,
  output ppm_gmode_e a_mode,
  output ppm_gmode_e b_mode
);

  // RULE4 flag selects format
  assign mode_set = wr_cw && wdata[PPM_CW_FLAG];
  // RULE5 bit command format
  assign bsr_hit = wr_cw && !wdata[PPM_CW_FLAG];
  // RULE23 line and value
  assign bsr_sel = wdata[PPM_BSR_SEL_HI:PPM_BSR_SEL_LO];
  assign bsr_val = wdata[PPM_BSR_VAL];

  // RULE3 one word configures
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg <= PPM_CW_RESET;
    end else if (ce && mode_set) begin
      cfg <= wdata;
    end
  end

  // Direction bits: a one makes the port or nibble an input.
  assign a_in = cfg[PPM_CW_ADIR];
  assign b_in = cfg[PPM_CW_BDIR];
  assign cu_in = cfg[PPM_CW_CUDIR];
  assign cl_in = cfg[PPM_CW_CLDIR];

  // RULE6 group mode select
  assign a_mode = (cfg[PPM_CW_MODEA_HI:PPM_CW_MODEA_LO] == PPM_MODE_BASIC) ? PPM_GM_BASIC :
                  (cfg[PPM_CW_MODEA_HI:PPM_CW_MODEA_LO] == PPM_MODE_STROBED && a_in) ?
                  PPM_GM_STROBED_IN : PPM_GM_OTHER;
  // RULE15 port B strobed input
  assign b_mode = !cfg[PPM_CW_MODEB] ? PPM_GM_BASIC : (b_in ? PPM_GM_STROBED_IN : PPM_GM_OTHER);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_cw_load: assert property (ce && mode_set |=> cfg == $past(wdata)) // RULE4
    else $error("Control word not loaded.");
  a_cw_bsr_keeps: assert property (ce && bsr_hit |=> $stable(cfg)) // RULE5
    else $error("Bit command changed the configuration.");

endmodule : ppm_cword

// ==== ppm_periph.sv ====
// Model of the external parallel peripheral that faces the core's pins.
module ppm_periph import ppm_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Core pin drives
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe_n,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  // Resolved pin levels
  output logic [7:0] pa_in,
  output logic [7:0] pb_in,
  output logic [7:0] pc_in
);
  logic [7:0] ext_a;
  logic [7:0] ext_b;
  logic [7:0] ext_c;

  // Strobe lines idle high so no capture happens by accident.
  initial begin
    ext_a = 8'h00;
    ext_b = 8'h00;
    ext_c = 8'hFF;
  end

  // A pin shows the core's value where it drives, else the peripheral's.
  assign pa_in = (pa_oe_n & ext_a) | (~pa_oe_n & pa_out);
  assign pb_in = (pb_oe_n & ext_b) | (~pb_oe_n & pb_out);
  assign pc_in = (pc_oe_n & ext_c) | (~pc_oe_n & pc_out);

  // strobe loads byte
  // Data stand before the strobe falls and are inverted once it rises again.
  task automatic strobe(input logic port_b, input logic [7:0] d, input int low_cyc);
    int bit_n;
    bit_n = port_b ? PPM_PC_B_STB : PPM_PC_A_STB;
    @(posedge clk_sys);
    if (port_b) begin
      ext_b <= d;
    end else begin
      ext_a <= d;
    end
    @(posedge clk_sys);
    ext_c[bit_n] <= 1'b0;
    repeat (low_cyc) @(posedge clk_sys);
    ext_c[bit_n] <= 1'b1;
    @(posedge clk_sys);
    if (port_b) begin
      ext_b <= ~d;
    end else begin
      ext_a <= ~d;
    end
  endtask : strobe
endmodule : ppm_periph

// ==== ppm_pkg.sv ====
// Shared constants and types for the parallel port core.
package ppm_pkg;

  // ************************************
  // Widths and register port addresses
  // ************************************
  localparam int PPM_PORT_W = 8;
  localparam int PPM_NIB_W = 4;
  localparam int PPM_ADDR_W = 2;
  localparam logic [1:0] PPM_ADDR_A = 2'h0;
  localparam logic [1:0] PPM_ADDR_B = 2'h1;
  localparam logic [1:0] PPM_ADDR_C = 2'h2;
  localparam logic [1:0] PPM_ADDR_CW = 2'h3;

  // ************************************
  // Control word fields and values
  // ************************************
  localparam int PPM_CW_FLAG = 7;
  localparam int PPM_CW_MODEA_HI = 6;
  localparam int PPM_CW_MODEA_LO = 5;
  localparam int PPM_CW_ADIR = 4;
  localparam int PPM_CW_CUDIR = 3;
  localparam int PPM_CW_MODEB = 2;
  localparam int PPM_CW_BDIR = 1;
  localparam int PPM_CW_CLDIR = 0;
  localparam int PPM_BSR_SEL_HI = 3;
  localparam int PPM_BSR_SEL_LO = 1;
  localparam int PPM_BSR_VAL = 0;
  localparam logic [1:0] PPM_MODE_BASIC = 2'h0;
  localparam logic [1:0] PPM_MODE_STROBED = 2'h1;
  localparam logic [7:0] PPM_CW_RESET = 8'h9B;
  localparam logic [7:0] PPM_CW_ALL_OUT = 8'h80;
  localparam logic [7:0] PPM_BYTE_ZERO = 8'h00;
  localparam logic [7:0] PPM_ALL_HIGH = 8'hFF;

  // ************************************
  // Port C line positions in strobed input
  // ************************************
  localparam int PPM_PC_A_STB = 4;
  localparam int PPM_PC_A_FULL = 5;
  localparam int PPM_PC_A_IE = 4;
  localparam int PPM_PC_A_IRQ = 3;
  localparam int PPM_PC_B_IE = 2;
  localparam int PPM_PC_B_STB = 2;
  localparam int PPM_PC_B_FULL = 1;
  localparam int PPM_PC_B_IRQ = 0;
  localparam logic [2:0] PPM_BSR_A_IE = 3'h4;
  localparam logic [2:0] PPM_BSR_B_IE = 3'h2;

  // Operating mode of one group as the core serves it.
  typedef enum logic [1:0] {PPM_GM_BASIC, PPM_GM_STROBED_IN, PPM_GM_OTHER} ppm_gmode_e;

endpackage : ppm_pkg

// ==== ppm_strobe_chan.sv ====
// One strobed input channel: data latch, buffer-full, enable and request.
module ppm_strobe_chan import ppm_pkg::*; #(
  parameter int W = PPM_PORT_W
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Peripheral side
  input wire logic enable,
  input wire logic strobe_n,
  input wire logic [W-1:0] din,
  // Host side
  input wire logic rd_take,
  input wire logic ie_wr,
  input wire logic ie_val,
  input wire logic clr,
  output logic [W-1:0] data,
  output logic full,
  output logic ie,
  output logic irq
);

  if (W < 1) begin : g_bad_width
    $error("Channel width must be at least one.");
  end

  logic stb_prev;
  logic capture;
  logic next_full;

  // RULE22 falling strobe loads
  assign capture = enable && stb_prev && !strobe_n;
  // RULE18 set beats read clear
  assign next_full = capture || (full && !rd_take && !clr);
  // RULE20 request is enable and full
  assign irq = ie && full;

  // Strobe history, latch, flag and enable.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stb_prev <= 1'b1;
      data <= '0;
      full <= 1'b0;
      ie <= 1'b0;
    end else if (ce) begin
      stb_prev <= strobe_n;
      full <= next_full;
      // RULE13 input data latched
      if (capture) begin
        data <= din;
      end
      // RULE19 enable via bit command
      if (clr) begin
        ie <= 1'b0;
      end else if (ie_wr) begin
        ie <= ie_val;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_capture;
    ce && capture;
  endsequence

  a_strobe_capture: assert property (s_capture |=> full && data == $past(din)) // RULE18
    else $error("Strobe did not capture the byte.");
  a_read_clears: assert property (ce && rd_take && !capture |=> !full) // RULE22
    else $error("Read did not clear buffer full.");
  a_ie_write: assert property (ce && ie_wr && !clr |=> ie == $past(ie_val)) // RULE19
    else $error("Interrupt enable not written.");

endmodule : ppm_strobe_chan
